//--- sp4c_ctrl.sv
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sp4c_ctrl (
  input  wire logic                             clk,
  input  wire logic                             rstn,
  sp4c_if.ctl                                   link,
  input  wire logic [sp4c_pkg::SP4C_ADDR_W-1:0] avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [3:0]                       avs_byteenable,
  input  wire logic [sp4c_pkg::SP4C_DATA_W-1:0] avs_writedata,
  output var  logic [sp4c_pkg::SP4C_DATA_W-1:0] avs_readdata,
  output var  logic                             avs_waitrequest
);
  import sp4c_pkg::*;

  logic [2:0]            ctrl;
  logic [SP4C_CNT_W-1:0] modulus;
  logic                  wr_go;
  logic                  counting;
  logic                  auto_hit;
  logic                  next_clear_n;

  function automatic logic sel(input logic [SP4C_ADDR_W-1:0] a, input logic [SP4C_ADDR_W-1:0] o);
    sel = (a == o);
  endfunction

  // one wait state per access
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];

  // read data, unmapped reads zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read && avs_waitrequest)
    begin
      avs_readdata <= 32'h0000_0000;
      if (sel(avs_address, SP4C_OFS_CTRL))
      begin
        avs_readdata[2:0] <= ctrl;
      end
      if (sel(avs_address, SP4C_OFS_PRESET))
      begin
        avs_readdata[SP4C_CNT_W-1:0] <= link.preset;
      end
      if (sel(avs_address, SP4C_OFS_MOD))
      begin
        avs_readdata[SP4C_CNT_W-1:0] <= modulus;
      end
      if (sel(avs_address, SP4C_OFS_STATUS))
      begin
        avs_readdata[SP4C_CNT_W-1:0] <= link.count;
        avs_readdata[SP4C_STAT_CARRY] <= link.carry;
      end
    end
  end

  // control register; enables change just after a rising edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= SP4C_CTRL_RESET;
    end
    else if (wr_go && sel(avs_address, SP4C_OFS_CTRL))
    begin
      ctrl <= avs_writedata[2:0];
    end
  end

  assign link.enable_p = ctrl[SP4C_CTRL_EN_P];
  assign link.enable_t = ctrl[SP4C_CTRL_EN_T];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.preset <= SP4C_PRESET_RST;
      modulus     <= SP4C_MOD_RESET;
    end
    else
    begin
      if (wr_go && sel(avs_address, SP4C_OFS_PRESET))
      begin
        link.preset <= avs_writedata[SP4C_CNT_W-1:0];
      end
      if (wr_go && sel(avs_address, SP4C_OFS_MOD))
      begin
        modulus <= avs_writedata[SP4C_CNT_W-1:0];
      end
    end
  end

  // load strobe, released right after a rising edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.load_n <= 1'b1;
    end
    else
    begin
      link.load_n <= !(wr_go && sel(avs_address, SP4C_OFS_CMD) && avs_writedata[SP4C_CMD_LOAD]);
    end
  end

  // modulus decode onto clear
  assign counting = link.enable_p && link.enable_t && link.load_n && link.clear_n;
  assign auto_hit = ctrl[SP4C_CTRL_AUTO]
                    && (((link.count == SP4C_CNT_W'(modulus - SP4C_CNT_ONE)) && counting)
                        || ((link.count == modulus) && link.clear_n));
  assign next_clear_n = !(auto_hit
                          || (wr_go && sel(avs_address, SP4C_OFS_CMD) && avs_writedata[SP4C_CMD_CLEAR]));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.clear_n <= 1'b1;
    end
    else
    begin
      link.clear_n <= next_clear_n;
    end
  end
endmodule
`default_nettype wire

//--- sp4c_pkg.sv
`default_nettype none
package sp4c_pkg;
  localparam int unsigned       SP4C_CNT_W       = 4;
  localparam int unsigned       SP4C_ADDR_W      = 5;
  localparam int unsigned       SP4C_DATA_W      = 32;
  localparam logic [3:0]        SP4C_CNT_RESET   = 4'h0;
  localparam logic [3:0]        SP4C_CNT_MAX     = 4'hf;
  localparam logic [3:0]        SP4C_CNT_ONE     = 4'h1;
  // register byte offsets
  localparam logic [4:0]        SP4C_OFS_CTRL    = 5'h00;
  localparam logic [4:0]        SP4C_OFS_PRESET  = 5'h04;
  localparam logic [4:0]        SP4C_OFS_CMD     = 5'h08;
  localparam logic [4:0]        SP4C_OFS_MOD     = 5'h0c;
  localparam logic [4:0]        SP4C_OFS_STATUS  = 5'h10;
  // ctrl fields
  localparam int unsigned       SP4C_CTRL_EN_P   = 0;
  localparam int unsigned       SP4C_CTRL_EN_T   = 1;
  localparam int unsigned       SP4C_CTRL_AUTO   = 2;
  localparam logic [2:0]        SP4C_CTRL_RESET  = 3'h0;
  // cmd fields
  localparam int unsigned       SP4C_CMD_LOAD    = 0;
  localparam int unsigned       SP4C_CMD_CLEAR   = 1;
  // status fields, preset and modulus reset values
  localparam int unsigned       SP4C_STAT_CARRY  = 4;
  localparam logic [3:0]        SP4C_PRESET_RST  = 4'h0;
  localparam logic [3:0]        SP4C_MOD_RESET   = 4'hf;
endpackage
`default_nettype wire

//--- sp4c_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sp4c_if;
  import sp4c_pkg::*;
  logic                  load_n;
  logic                  clear_n;
  logic                  enable_p;
  logic                  enable_t;
  logic [SP4C_CNT_W-1:0] preset;
  logic [SP4C_CNT_W-1:0] count;
  logic                  carry;
  modport dev (
    input  load_n,
    input  clear_n,
    input  enable_p,
    input  enable_t,
    input  preset,
    output count,
    output carry
  );
  modport ctl (
    output load_n,
    output clear_n,
    output enable_p,
    output enable_t,
    output preset,
    input  count,
    input  carry
  );
endinterface
`default_nettype wire

//--- sp4c_counter.sv
`timescale 1ns/100ps
`default_nettype none
module sp4c_counter (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  sp4c_if.dev                                 link,
  output var  logic [sp4c_pkg::SP4C_CNT_W-1:0] count_q,
  output var  logic                           lowest_count_bit,
  output var  logic                           ripple_carry
);
  import sp4c_pkg::*;

  logic [SP4C_CNT_W-1:0] cnt;
  logic [SP4C_CNT_W-1:0] next_cnt;

  // next count selection
  always_comb
  begin
    if (!link.clear_n)
    begin
      next_cnt = SP4C_CNT_RESET;
    end
    else if (!link.load_n)
    begin
      next_cnt = link.preset;
    end
    else if (link.enable_p && link.enable_t)
    begin
      next_cnt = SP4C_CNT_W'(cnt + SP4C_CNT_ONE);
    end
    else
    begin
      next_cnt = cnt;
    end
  end

  // single register for all stages
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= SP4C_CNT_RESET;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end

  // carry look-ahead, enable t fed forward
  always_comb
  begin
    ripple_carry = link.enable_t && (cnt == SP4C_CNT_MAX);
  end

  assign count_q          = cnt;
  assign lowest_count_bit = cnt[0];
  assign link.count       = cnt;
  assign link.carry       = ripple_carry;
endmodule
`default_nettype wire

//--- sp4c_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sp4c_properties (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       load_n,
  input wire logic       clear_n,
  input wire logic       enable_p,
  input wire logic       enable_t,
  input wire logic [3:0] preset,
  input wire logic [3:0] count,
  input wire logic       carry
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // plain count step
  sequence s_step;
    clear_n && load_n && enable_p && enable_t;
  endsequence
  a_clear_zero: assert property (!clear_n |=> count == 4'h0) else $error("clear missed");
  a_load_copy: assert property (clear_n && !load_n |=> count == $past(preset)) else $error("load missed");
  a_count_up: assert property (s_step |=> count == $past(count) + 4'h1) else $error("bad step");
  a_hold_idle: assert property (clear_n && load_n && !enable_p |=> $stable(count)) else $error("moved");
  a_hold_no_t: assert property (clear_n && load_n && !enable_t |=> $stable(count)) else $error("moved on t");
  a_carry_gate: assert property (!enable_t |-> !carry) else $error("carry ungated");
  a_carry_full: assert property (enable_t && count == 4'hf |-> carry) else $error("no carry");
  a_carry_pulse: assert property (carry |-> count[0]) else $error("carry off lsb");
  a_wrap_zero: assert property (s_step ##0 count == 4'hf |=> count == 4'h0) else $error("no wrap");
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sp4c_pkg::*;
  typedef struct packed {logic [4:0] a; logic [3:0] d; logic [4:0] e;} sp4c_row_t;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        wait_r;
  logic [3:0]  cnt;
  logic        lsb;
  logic        rc;
  logic [3:0]  cnt_hi;
  logic [3:0]  be = 4'hf;
  logic [31:0] q;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  sp4c_row_t   rows [9] = '{'{5'h04, 4'h9, 5'h00}, '{5'h08, 4'h1, 5'h09}, '{5'h00, 4'h2, 5'h09},
    '{5'h04, 4'hf, 5'h09}, '{5'h08, 4'h1, 5'h1f}, '{5'h00, 4'h1, 5'h0f}, '{5'h08, 4'h3, 5'h00},
    '{5'h10, 4'h0, 5'h00}, '{5'h14, 4'h5, 5'h00}};
  sp4c_if link();
  sp4c_counter i_sp4c_counter (.clk(clk), .rstn(rstn), .link(link), .count_q(cnt), .lowest_count_bit(lsb),
    .ripple_carry(rc));
  sp4c_ctrl i_sp4c_ctrl (.clk(clk), .rstn(rstn), .link(link), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_r));
  sp4c_properties u_props (.clk(clk), .rstn(rstn), .load_n(link.load_n), .clear_n(link.clear_n),
    .enable_p(link.enable_p), .enable_t(link.enable_t), .preset(link.preset), .count(link.count), .carry(link.carry));
  sp4c_if link_hi();
  assign link_hi.load_n   = link.load_n;
  assign link_hi.clear_n  = link.clear_n;
  assign link_hi.enable_p = link.enable_p;
  assign link_hi.enable_t = link.carry;
  assign link_hi.preset   = link.preset;
  sp4c_counter i_sp4c_counter_hi (.clk(clk), .rstn(rstn), .link(link_hi), .count_q(cnt_hi), .lowest_count_bit(),
    .ripple_carry());
  always #5 clk = ~clk;
  task close_out;
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask
  task bus(input logic [4:0] a, input logic w, input logic [3:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {28'h0, d};
    do @(posedge clk); while (wait_r !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task upto(input logic [3:0] v);
    repeat (40)
    begin
      @(posedge clk);
      #1;
      if (cnt === v)
        break;
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      close_out;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    bus(SP4C_OFS_STATUS, 1'b0, 4'h0);
    chk(q, 32'h0);
    bus(SP4C_OFS_MOD, 1'b0, 4'h0);
    chk(q, 32'hf);
    foreach (rows[i])
    begin
      bus(rows[i].a, 1'b1, rows[i].d);
      bus(SP4C_OFS_STATUS, 1'b0, 4'h0);
      chk(q, {27'h0, rows[i].e});
    end
    bus(SP4C_OFS_PRESET, 1'b1, 4'hd);
    bus(SP4C_OFS_CMD, 1'b1, 4'h1);
    bus(SP4C_OFS_CTRL, 1'b1, 4'h3);
    upto(4'hf);
    chk({26'h0, cnt, lsb, rc}, 32'h3f);
    chk({28'h0, cnt_hi}, 32'hd);
    @(posedge clk);
    #1;
    chk({27'h0, cnt, rc}, 32'h0);
    chk({28'h0, cnt_hi}, 32'he);
    bus(SP4C_OFS_MOD, 1'b1, 4'h5);
    bus(SP4C_OFS_CTRL, 1'b1, 4'h7);
    upto(4'h5);
    chk({28'h0, cnt}, 32'h5);
    chk({28'h0, cnt_hi}, 32'hf);
    @(posedge clk);
    #1;
    chk({28'h0, cnt}, 32'h0);
    chk({28'h0, cnt_hi}, 32'h0);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    bus(SP4C_OFS_CTRL, 1'b0, 4'h0);
    chk(q, 32'h0);
    chk({27'h0, cnt, rc}, 32'h0);
    bus(SP4C_OFS_CMD, 1'b0, 4'h0);
    chk(q, 32'h0);
    be <= 4'he;
    bus(SP4C_OFS_CTRL, 1'b1, 4'h3);
    be <= 4'hf;
    bus(SP4C_OFS_CTRL, 1'b0, 4'h0);
    chk(q, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
